// >>> inc/swr_consts.vh
// Purpose: constants for the single-wire receive master
// Assumes: 50 MHz clock, 20 ns period
// Notes:   times in ns, cycle counts derived from them
`ifndef SWR_CONSTS_VH
`define SWR_CONSTS_VH

`define SWR_CLK_PERIOD_NS  20
// Mode field positions
`define SWR_MODE_RST_BEFORE 0
`define SWR_MODE_RST_AFTER  1
`define SWR_MODE_BITWISE    2
// Bus timing, in nanoseconds
`define SWR_T_RESET_NS     480000
`define SWR_T_PRES_WAIT_NS 70000
`define SWR_T_PRES_END_NS  410000
`define SWR_T_SLOT_LOW_NS  2000
`define SWR_T_SAMPLE_NS    13000
`define SWR_T_SLOT_NS      65000
// Cycle counts: least times round up, the sample point rounds down
`define SWR_CYC_RESET     ((`SWR_T_RESET_NS + `SWR_CLK_PERIOD_NS - 1) / `SWR_CLK_PERIOD_NS)
`define SWR_CYC_PRES_WAIT ((`SWR_T_PRES_WAIT_NS + `SWR_CLK_PERIOD_NS - 1) / `SWR_CLK_PERIOD_NS)
`define SWR_CYC_PRES_END  ((`SWR_T_PRES_END_NS + `SWR_CLK_PERIOD_NS - 1) / `SWR_CLK_PERIOD_NS)
`define SWR_CYC_SLOT_LOW  ((`SWR_T_SLOT_LOW_NS + `SWR_CLK_PERIOD_NS - 1) / `SWR_CLK_PERIOD_NS)
`define SWR_CYC_SAMPLE    (`SWR_T_SAMPLE_NS / `SWR_CLK_PERIOD_NS)
`define SWR_CYC_SLOT      ((`SWR_T_SLOT_NS + `SWR_CLK_PERIOD_NS - 1) / `SWR_CLK_PERIOD_NS)
// Byte width and array depth
`define SWR_BYTE_BITS     8
`define SWR_ARRAY_DEPTH   16
`define SWR_IDX_W         4

`endif

// >>> core/swr_line_phy.v
// Purpose: line timing engine: reset/presence and single read slots
// Assumes: synchronous line input, open-drain pin, oe low means driving low
// Notes:   one operation per start pulse; done is a one-cycle pulse
`timescale 1ns/1ps
`include "swr_consts.vh"
module swr_line_phy
#(
  parameter RESET_CYC = `SWR_CYC_RESET,
  parameter PWAIT_CYC = `SWR_CYC_PRES_WAIT,
  parameter PEND_CYC  = `SWR_CYC_PRES_END
)
(
  input  wire        clock,
  input  wire        rst_n,
  input  wire        start_reset,
  input  wire        start_slot,
  input  wire        line_in,
  output reg         line_oe_n,
  output reg         done,
  output reg         bit_val,
  output reg         presence
);
  // Phase codes
  localparam IDLE = 2'h0;
  localparam RLOW = 2'h1;
  localparam RREL = 2'h2;
  localparam SLOT = 2'h3;

  reg [1:0]  phase_reg;  // Current phase
  reg [15:0] cnt_reg;    // Cycle counter within phase
  reg        seen_reg;   // Presence low seen in window

  // Line drive and timing sequencer
  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      phase_reg <= IDLE;
      cnt_reg   <= 16'h0000;
      seen_reg  <= 1'b0;
      line_oe_n <= 1'b1;
      done      <= 1'b0;
      bit_val   <= 1'b0;
      presence  <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      case (phase_reg)
        IDLE:
        begin
          cnt_reg <= 16'h0000;
          // Reset pulse wins when both asked, though the core never does
          if (start_reset)
          begin
            phase_reg <= RLOW;
            line_oe_n <= 1'b0;
          end
          else if (start_slot)
          begin
            phase_reg <= SLOT;
            line_oe_n <= 1'b0;
          end
        end
        RLOW:
        begin
          // Master holds the line low for the reset pulse
          cnt_reg <= cnt_reg + 16'h0001;
          if (cnt_reg == RESET_CYC - 1)
          begin
            phase_reg <= RREL;
            line_oe_n <= 1'b1; // RULE9
            cnt_reg   <= 16'h0000;
            seen_reg  <= 1'b0;
          end
        end
        RREL:
        begin
          // Slaves answer with a low presence pulse
          cnt_reg <= cnt_reg + 16'h0001;
          if (cnt_reg >= PWAIT_CYC && !line_in)
            seen_reg <= 1'b1; // RULE15
          if (cnt_reg == PEND_CYC - 1)
          begin
            phase_reg <= IDLE;
            presence  <= seen_reg;
            done      <= 1'b1;
          end
        end
        SLOT:
        begin
          cnt_reg <= cnt_reg + 16'h0001;
          // Brief low, then release so the slave may hold it low
          if (cnt_reg == `SWR_CYC_SLOT_LOW - 1)
            line_oe_n <= 1'b1; // RULE16
          if (cnt_reg == `SWR_CYC_SAMPLE - 1)
            bit_val <= line_in; // RULE16
          if (cnt_reg == `SWR_CYC_SLOT - 1)
          begin
            phase_reg <= IDLE;
            done      <= 1'b1;
          end
        end
        default:
        begin
          phase_reg <= IDLE;
          line_oe_n <= 1'b1;
        end
      endcase
    end
  end
endmodule // swr_line_phy

// >>> core/swr_read_master.v
// Overview of operation
// RULE1: Caller supplies mode zero to seven.
// RULE2: Mode one: reset, then receive bytes.
// RULE3: Mode two: bytes, then reset after.
// RULE4: Mode three: reset before and after bytes.
// RULE5: Mode five: reset, then one bit each.
// RULE6: Mode six: bits, then reset after.
// RULE7: Mode seven: reset before and after bits.
// RULE8: Check presence before any data after reset.
// RULE9: Line always released to input when done.
// RULE10: Bit mode: one bit per destination, in order.
// RULE11: Bit mode stores single bit, never byte.
// RULE12: Array fill: consecutive elements from first.
// RULE13: Explicit length stops fill at count.
// RULE14: Controller picks no-reset or reset-after mode.
// RULE15: Reset pulse answered by slave presence pulse.
// RULE16: Low pulse, sample within 15 us.
// RULE17: Bytes are eight bits, LSB first.
// RULE18: Assemble LSB first; flag absent presence.
//
// Purpose: single-wire bus receive engine, one operation per start
// Assumes: mode held stable from start to done; line input synchronous
// Notes:   destinations are counted entries; results appear on a write strobe
//          a missing presence after the opening reset skips the data and leaves absent set until next start
`timescale 1ns/1ps
`include "swr_consts.vh"
module swr_read_master
#(
  parameter RESET_CYC = `SWR_CYC_RESET,
  parameter PWAIT_CYC = `SWR_CYC_PRES_WAIT,
  parameter PEND_CYC  = `SWR_CYC_PRES_END
)
(
  input  wire       clock,
  input  wire       rst_n,
  input  wire       start,
  input  wire [2:0] mode,
  input  wire       array_fill_option,
  input  wire [4:0] item_count,
  input  wire       line_in,
  output reg        line_out,
  output reg        line_oe_n,
  output reg        busy,
  output reg        done,
  output reg        absent,
  output reg        dest_we,
  output reg  [3:0] dest_idx,
  output reg  [7:0] dest_data,
  output reg        arr_we,
  output reg  [3:0] arr_idx,
  output reg  [7:0] arr_data
);
  // Sequencer states
  localparam S_IDLE   = 3'h0;
  localparam S_PRE    = 3'h1;
  localparam S_SLOT   = 3'h2;
  localparam S_STORE  = 3'h3;
  localparam S_POST   = 3'h4;
  localparam S_FINISH = 3'h5;

  // Array size as an item count; sized so the clip keeps the count width
  localparam [4:0] ARR_DEPTH = `SWR_ARRAY_DEPTH;

  reg [2:0] state_reg;      // Sequencer state
  reg [2:0] mode_reg;       // Captured transfer mode
  reg       fill_reg;       // Captured array-fill option
  reg [4:0] left_reg;       // Items still to receive
  reg [3:0] idx_reg;        // Next destination index
  reg [2:0] bitn_reg;       // Bit position within byte
  reg [7:0] shift_reg;      // Byte being assembled
  reg       wait_reg;       // Waiting on the phy done pulse
  reg       go_rst_reg;     // Phy reset request pulse
  reg       go_slot_reg;    // Phy slot request pulse

  wire      phy_oe_n;       // Phy line drive, low drives low
  wire      phy_done;       // Phy operation finished
  wire      phy_bit;        // Sampled slot bit
  wire      phy_pres;       // Presence seen after reset
  wire [4:0] start_count;   // Items for a new operation

  // Limits an item count to what the array holds
  function [4:0] clip_count;
    input [4:0] n;
    begin
      if (n == 5'h00 || n > ARR_DEPTH)
        clip_count = ARR_DEPTH;
      else
        clip_count = n;
    end
  endfunction

  // Bit mode ignores the array fill: each entry takes one bit
  // One count drives both start paths, so a clipped zero still reads
  assign start_count = (array_fill_option && !mode[`SWR_MODE_BITWISE]) ?
                       clip_count(item_count) : item_count; // RULE13

  swr_line_phy
  #(
    .RESET_CYC (RESET_CYC),
    .PWAIT_CYC (PWAIT_CYC),
    .PEND_CYC  (PEND_CYC)
  )
  u_phy
  (
    .clock       (clock),
    .rst_n       (rst_n),
    .start_reset (go_rst_reg),
    .start_slot  (go_slot_reg),
    .line_in     (line_in),
    .line_oe_n   (phy_oe_n),
    .done        (phy_done),
    .bit_val     (phy_bit),
    .presence    (phy_pres)
  );

  // Registered copy of the phy drive; released whenever idle
  // Releasing in idle keeps the pin an input between operations
  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      line_oe_n <= 1'b1;
      line_out  <= 1'b0;
    end
    else
    begin
      line_out  <= 1'b0;
      line_oe_n <= (state_reg == S_IDLE) ? 1'b1 : phy_oe_n; // RULE9
    end
  end

  // Receive sequencer
  // One item at a time: slots, a store, then the next item or the close
  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      state_reg   <= S_IDLE;
      mode_reg    <= 3'h0;
      fill_reg    <= 1'b0;
      left_reg    <= 5'h00;
      idx_reg     <= 4'h0;
      bitn_reg    <= 3'h0;
      shift_reg   <= 8'h00;
      wait_reg    <= 1'b0;
      go_rst_reg  <= 1'b0;
      go_slot_reg <= 1'b0;
      busy        <= 1'b0;
      done        <= 1'b0;
      absent      <= 1'b0;
      dest_we     <= 1'b0;
      dest_idx    <= 4'h0;
      dest_data   <= 8'h00;
      arr_we      <= 1'b0;
      arr_idx     <= 4'h0;
      arr_data    <= 8'h00;
    end
    else
    begin
      go_rst_reg  <= 1'b0;
      go_slot_reg <= 1'b0;
      done        <= 1'b0;
      dest_we     <= 1'b0;
      arr_we      <= 1'b0;
      case (state_reg)
        S_IDLE:
        begin
          if (start)
          begin
            mode_reg  <= mode; // RULE1
            fill_reg  <= array_fill_option;
            left_reg  <= start_count; // RULE13
            idx_reg   <= 4'h0; // RULE12
            bitn_reg  <= 3'h0;
            shift_reg <= 8'h00;
            busy      <= 1'b1;
            absent    <= 1'b0;
            wait_reg  <= 1'b1;
            // Modes 1,3,5,7 reset first; 0,4 never reset
            if (mode[`SWR_MODE_RST_BEFORE])
            begin
              go_rst_reg <= 1'b1; // RULE2 RULE4 RULE5 RULE7
              state_reg  <= S_PRE;
            end
            else
            begin
              go_slot_reg <= (start_count != 5'h00);
              state_reg   <= (start_count != 5'h00) ? S_SLOT : S_POST;
              wait_reg    <= (start_count != 5'h00);
            end
          end
        end
        S_PRE:
        begin
          // Presence decides whether any data is read
          // Absence skips both the data and the closing reset
          if (phy_done)
          begin
            if (!phy_pres)
            begin
              absent    <= 1'b1; // RULE18
              state_reg <= S_FINISH;
            end
            else if (left_reg == 5'h00)
              state_reg <= S_POST;
            else
            begin
              go_slot_reg <= 1'b1; // RULE8
              state_reg   <= S_SLOT;
            end
          end
        end
        S_SLOT:
        begin
          if (phy_done)
          begin
            // New bit enters at the top so bit 0 ends up first received
            shift_reg <= {phy_bit, shift_reg[7:1]}; // RULE17 RULE18
            // Bit mode stores after one slot, byte mode after eight
            if (mode_reg[`SWR_MODE_BITWISE] ||
                bitn_reg == `SWR_BYTE_BITS - 1)
              state_reg <= S_STORE;
            else
            begin
              bitn_reg    <= bitn_reg + 3'h1;
              go_slot_reg <= 1'b1;
            end
          end
        end
        S_STORE:
        begin
          bitn_reg <= 3'h0;
          if (mode_reg[`SWR_MODE_BITWISE])
          begin
            // Only one bit goes to a byte-wide destination
            dest_data <= {7'h00, shift_reg[7]}; // RULE10 RULE11
            dest_we   <= 1'b1;
            dest_idx  <= idx_reg;
          end
          else if (fill_reg)
          begin
            arr_data <= shift_reg; // RULE12
            arr_idx  <= idx_reg;
            arr_we   <= 1'b1;
          end
          else
          begin
            dest_data <= shift_reg; // RULE2
            dest_idx  <= idx_reg;
            dest_we   <= 1'b1;
          end
          // Count down; the last item moves on to the closing phase
          idx_reg   <= idx_reg + 4'h1;
          left_reg  <= left_reg - 5'h01;
          shift_reg <= 8'h00;
          if (left_reg == 5'h01)
            state_reg <= S_POST; // RULE13
          else
          begin
            go_slot_reg <= 1'b1;
            state_reg   <= S_SLOT;
          end
        end
        S_POST:
        begin
          // Modes 2,3,6,7 end with a reset after the last item
          // wait_reg low: reset not yet asked; high: waiting on the phy
          if (!mode_reg[`SWR_MODE_RST_AFTER])
            state_reg <= S_FINISH;
          else if (!wait_reg)
          begin
            go_rst_reg <= 1'b1; // RULE3 RULE4 RULE6 RULE7
            wait_reg   <= 1'b1;
          end
          else if (phy_done)
          begin
            absent    <= !phy_pres; // RULE18
            state_reg <= S_FINISH;
          end
          if (state_reg == S_POST && mode_reg[`SWR_MODE_RST_AFTER] && go_rst_reg)
            wait_reg <= 1'b1;
        end
        S_FINISH:
        begin
          // Busy falls with the pulse, so a start is taken the next cycle
          busy      <= 1'b0;
          done      <= 1'b1;
          wait_reg  <= 1'b0;
          state_reg <= S_IDLE;
        end
        default:
        begin
          // Unused codes fall back to idle and release the sequencer
          state_reg <= S_IDLE;
          busy      <= 1'b0;
        end
      endcase
      // Only the closing phase and a start with a reset first keep the wait flag
      // Entering post phase needs a fresh request
      if (state_reg != S_POST &&
          !(state_reg == S_IDLE && start && mode[`SWR_MODE_RST_BEFORE]))
        wait_reg <= (state_reg == S_IDLE && start) ? 1'b0 : wait_reg & 1'b0;
    end
  end
endmodule // swr_read_master

// >>> test/swr_read_master_assertions.sv
// Purpose: port checks for the receive master
// Assumes: one clock, synchronous active-low reset
// Notes:   bound to every swr_read_master
`timescale 1ns/1ps
module swr_read_master_chk
(
  input wire       clock,
  input wire       rst_n,
  input wire       start,
  input wire [2:0] mode,
  input wire       line_out,
  input wire       line_oe_n,
  input wire       busy,
  input wire       done,
  input wire       absent,
  input wire       dest_we,
  input wire [3:0] dest_idx,
  input wire [7:0] dest_data,
  input wire       arr_we
);
  reg [3:0] cnt_reg; // Destination writes since start
  // Restarts on reset or on an accepted start only
  always @(posedge clock)
    if (!rst_n || (start && !busy)) cnt_reg <= 4'h0;
    else if (dest_we) cnt_reg <= cnt_reg + 4'h1;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_low_only: assert property (line_out == 1'b0)
    else $error("line driven high");
  a_idle_released: assert property (!busy |-> line_oe_n)
    else $error("line held while idle");
  a_done_ends_busy: assert property (done |-> !busy ##1 !done)
    else $error("done not a single closing pulse");
  a_start_clears: assert property (start && !busy |=> busy && !absent)
    else $error("start not taken");
  a_slot_low_min: assert property ($fell(line_oe_n) |-> !line_oe_n[*8])
    else $error("low pulse too short");
  a_bit_single: assert property (dest_we && mode[2] |-> dest_data[7:1] == 7'h0)
    else $error("bit mode stored more than a bit");
  a_write_busy: assert property (dest_we || arr_we |-> busy)
    else $error("write outside an operation");
  a_no_data_absent: assert property (absent && busy |-> !dest_we && !arr_we)
    else $error("data after missing presence");
  a_dest_order: assert property (dest_we |-> dest_idx == cnt_reg)
    else $error("destination out of order");
endmodule // swr_read_master_chk
bind swr_read_master swr_read_master_chk u_chk (.clock(clock), .rst_n(rst_n), .start(start),
  .mode(mode), .line_out(line_out), .line_oe_n(line_oe_n), .busy(busy), .done(done),
  .absent(absent), .dest_we(dest_we), .dest_idx(dest_idx), .dest_data(dest_data),
  .arr_we(arr_we));

// >>> test/swr_slave_model.sv
// Purpose: slave on the shared line
// Assumes: master low for 200 cycles or more is a reset
// Notes:   answers bits after release; a real slave holds from the fall
`timescale 1ns/1ps
module swr_slave_model
(
  input  wire        clock,
  input  wire        line_oe_n,
  input  wire        present,
  input  wire        load,
  input  wire [31:0] pattern,
  output wire        pull
);
  integer low_cnt = 0; // Master low time
  integer hold    = 0; // Our own low time left
  integer idx     = 0; // Next bit to send
  assign pull = (hold != 0);
  // Presence after resets, pattern bits in read slots
  always @(posedge clock)
  begin
    if (hold != 0) hold <= hold - 1;
    if (load) idx <= 0;
    if (!line_oe_n) low_cnt <= low_cnt + 1;
    else
    begin
      low_cnt <= 0;
      // Presence must cover the master's sample window
      if (low_cnt >= 200 && present) hold <= 150;
      else if (low_cnt > 0 && low_cnt < 200)
      begin
        if (!pattern[idx]) hold <= 600;
        idx <= idx + 1;
      end
    end
  end
endmodule // swr_slave_model

// >>> test/tb.sv
// Purpose: self-checking bench for the receive master
// Assumes: short reset parameters keep the run small
// Notes:   expectations come from the slave pattern
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin \
    total_checks = total_checks + 1; \
    if ((e) !== (g)) \
    begin \
      bad_count = bad_count + 1; \
      $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
    end \
  end
module tb;
  reg         clock = 1'b0;
  reg         rst_n = 1'b0;
  reg         start = 1'b0;
  reg  [2:0]  mode = 3'h0;
  reg         fill = 1'b0;
  reg  [4:0]  item_count = 5'h0;
  reg         present = 1'b1;
  reg         load = 1'b0;
  reg  [31:0] pat = 32'h0;
  reg  [15:0] seed = 16'ha398; // Fixed seed
  wire        pull, line_out, line_oe_n, busy, done, absent, dest_we, arr_we;
  wire [3:0]  dest_idx, arr_idx;
  wire [7:0]  dest_data, arr_data;
  wire        line_w = !line_oe_n ? line_out : !pull; // Pull-up when free
  integer     bad_count = 0, total_checks = 0, cyc = 0, widx = 0, aidx = 0;
  integer     nrst = 0, lowrun = 0, m;
  always #10 clock = ~clock;
  swr_read_master #(.RESET_CYC(400), .PWAIT_CYC(5), .PEND_CYC(300)) uut (.clock(clock),
    .rst_n(rst_n), .start(start), .mode(mode), .array_fill_option(fill),
    .item_count(item_count), .line_in(line_w), .line_out(line_out), .line_oe_n(line_oe_n),
    .busy(busy), .done(done), .absent(absent), .dest_we(dest_we), .dest_idx(dest_idx),
    .dest_data(dest_data), .arr_we(arr_we), .arr_idx(arr_idx), .arr_data(arr_data));
  swr_slave_model u_slave (.clock(clock), .line_oe_n(line_oe_n), .present(present),
    .load(load), .pattern(pat), .pull(pull));
  function [15:0] lfsr(input [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Bytes gather LSB first; bit mode keeps one bit
  function [7:0] exp_val(input integer j);
    exp_val = mode[2] ? {7'h0, pat[j]} : pat[8*j +: 8];
  endfunction
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  // Scores writes, counts long master lows as resets, cuts hangs
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    lowrun <= line_oe_n ? 0 : lowrun + 1;
    if (line_oe_n && lowrun >= 200) nrst <= nrst + 1;
    if (dest_we)
    begin
      `CHK("dest_idx", widx[3:0], dest_idx)
      `CHK("dest_data", exp_val(widx), dest_data)
      widx <= widx + 1;
    end
    if (arr_we)
    begin
      `CHK("arr_idx", aidx[3:0], arr_idx)
      `CHK("arr_data", exp_val(aidx), arr_data)
      aidx <= aidx + 1;
    end
    // Counters restart with each new pattern
    if (load)
    begin
      widx <= 0;
      aidx <= 0;
      nrst <= 0;
    end
    if (cyc == 95000)
    begin
      bad_count = bad_count + 1;
      end_of_test;
    end
  end
  // One operation; a second start while busy must be ignored
  task run(input [2:0] md, input f, input [4:0] n, input p);
    integer k, nw, er;
    begin
      seed = lfsr(seed);
      k = seed;
      seed = lfsr(seed);
      @(posedge clock);
      mode <= md;
      fill <= f;
      item_count <= n;
      present <= p;
      load <= 1'b1;
      pat <= {seed, k[15:0]};
      @(posedge clock);
      load <= 1'b0;
      start <= 1'b1;
      @(posedge clock);
      start <= 1'b0;
      repeat (5) @(posedge clock);
      start <= 1'b1;
      @(posedge clock);
      start <= 1'b0;
      for (k = 0; k < 60000 && done !== 1'b1; k = k + 1)
        @(posedge clock);
      `CHK("done", 1'b1, done)
      repeat (3) @(posedge clock);
      #1;
      nw = (md[0] && !p) ? 0 : n;
      er = md[0] + ((md[1] && !(md[0] && !p)) ? 1 : 0);
      `CHK("dest writes", (f && !md[2]) ? 0 : nw, widx)
      `CHK("arr writes", (f && !md[2]) ? nw : 0, aidx)
      `CHK("resets", er, nrst)
      `CHK("absent", (er > 0) ? !p : 1'b0, absent)
      `CHK("line_oe_n", 1'b1, line_oe_n)
      `CHK("busy", 1'b0, busy)
    end
  endtask
  initial
  begin
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    run(3'h1, 1'b0, 5'h01, 1'b1);
    run(3'h0, 1'b1, 5'h01, 1'b1);
    for (m = 4; m < 8; m = m + 1)
      run(m[2:0], 1'b0, 5'h02, 1'b1);
    run(3'h3, 1'b0, 5'h01, 1'b0);
    run(3'h2, 1'b0, 5'h00, 1'b1);
    end_of_test;
  end
endmodule // tb
